// ===== inc/pdhm_pkg.sv
package pdhm_pkg;
  // instrument clock and the one-second tick
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_S * CLK_FREQ_HZ;

  // default line rate, bits per second (2.048 Mbit/s)
  localparam int LINE_RATE_BPS_DEF = 2_048_000;

  // severe-error threshold: errors * SES_RATIO_DEN >= bits in the second
  localparam logic [63:0] SES_RATIO_DEN = 64'h0000_0000_0000_03e8;

  // consecutive seconds that decide entry to and exit from unavailability
  localparam logic [3:0] UNAV_RUN = 4'ha;

  // standard selection codes
  localparam logic [1:0] STD_FIRST = 2'h0;
  localparam logic [1:0] STD_SECOND = 2'h1;
  localparam logic [1:0] STD_THIRD = 2'h2;

  // objectives in thousandths: pass when count * OBJ_DEN <= obj * available
  localparam logic [63:0] OBJ_DEN = 64'h0000_0000_0000_03e8;
  localparam logic [7:0] ES_OBJ_FIRST = 8'h50;
  localparam logic [7:0] ES_OBJ_SECOND = 8'h28;
  localparam logic [7:0] ES_OBJ_THIRD = 8'h14;
  localparam logic [7:0] SES_OBJ_FIRST = 8'h02;
  localparam logic [7:0] SES_OBJ_SECOND = 8'h02;
  localparam logic [7:0] SES_OBJ_THIRD = 8'h01;

  typedef enum logic [1:0] {
    ST_AVAIL = 2'b01,
    ST_UNAVAIL = 2'b10
  } pdhm_state_t;
endpackage

// ===== src/pdhm_monitor.sv
`timescale 1ns/100ps
module pdhm_monitor import pdhm_pkg::*; #(
  parameter int CW = 32,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int LINE_RATE_BPS = LINE_RATE_BPS_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic MEAS_RUN_I,
  input wire logic POWER_OK_I,
  input wire logic ERR_I,
  input wire logic ALARM_IND_I,
  input wire logic LOSS_OF_SIGNAL_I,
  input wire logic [1:0] STD_SEL_I,
  output logic SECOND_TICK_O,
  output logic UNAVAIL_O,
  output logic [CW-1:0] TOTAL_TIME_O,
  output logic [CW-1:0] UNAVAILABLE_TIME_O,
  output logic [CW-1:0] AVAILABLE_TIME_O,
  output logic [CW-1:0] ERRORED_SECOND_COUNT_O,
  output logic [CW-1:0] SEVERE_SECOND_COUNT_O,
  output logic [CW-1:0] ALARM_SECOND_COUNT_O,
  output logic [CW-1:0] ERROR_FREE_SECOND_COUNT_O,
  output logic [CW-1:0] BACKGROUND_ERROR_COUNT_O,
  output logic BACKGROUND_VALID_O,
  output logic ES_PASS_O,
  output logic SES_PASS_O
);

  typedef struct packed {
    logic run_s1;
    logic run_s2;
    logic run_d;
    logic pwr_s1;
    logic pwr_s2;
    logic measuring;
    logic [31:0] tick_cnt;
    logic tick;
    logic [CW-1:0] err_cnt;
    logic alarm_seen;
    pdhm_state_t state;
    logic unav_flag;
    logic [3:0] run_len;
    logic [3:0] p_es;
    logic [3:0] p_ses;
    logic [3:0] p_als;
    logic [3:0] p_efs;
    logic [CW-1:0] p_bbe;
    logic [CW-1:0] total;
    logic [CW-1:0] unav;
    logic [CW-1:0] avail;
    logic [CW-1:0] es;
    logic [CW-1:0] severe_second_count;
    logic [CW-1:0] alarm_second_count;
    logic [CW-1:0] error_free_second_count;
    logic [CW-1:0] bbe;
    logic bbe_valid;
    logic es_pass;
    logic ses_pass;
  } pdhm_regs_t;

  pdhm_regs_t r_q;
  pdhm_regs_t r_d;

  function automatic logic [CW-1:0] ext4(input logic [3:0] v);
    ext4 = {{(CW-4){1'b0}}, v};
  endfunction

  // one count step when the condition held in the closing second
  function automatic logic [3:0] one_if(input logic c);
    one_if = c ? 4'h1 : 4'h0;
  endfunction

  // count/avail <= obj/1000 without a divider; empty available time passes only a zero count
  function automatic logic ratio_ok(input logic [CW-1:0] cnt, input logic [CW-1:0] av, input logic [7:0] obj);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(cnt) * OBJ_DEN;
    rhs = 64'(av) * 64'(obj);
    ratio_ok = (lhs <= rhs);
  endfunction

  logic [7:0] es_obj;
  logic [7:0] ses_obj;
  logic sec_err;
  logic sec_alarm;
  logic sec_ses;
  logic sec_end;
  logic alarm_now;

  always_comb begin
    case (STD_SEL_I)
      STD_FIRST: begin
        es_obj = ES_OBJ_FIRST;
        ses_obj = SES_OBJ_FIRST;
      end
      STD_SECOND: begin
        es_obj = ES_OBJ_SECOND;
        ses_obj = SES_OBJ_SECOND;
      end
      default: begin
        // code 3 is treated as the third standard
        es_obj = ES_OBJ_THIRD;
        ses_obj = SES_OBJ_THIRD;
      end
    endcase
  end

  assign sec_err = (r_q.err_cnt != '0);
  // either defect marks the whole second as alarmed
  assign alarm_now = ALARM_IND_I || LOSS_OF_SIGNAL_I;
  assign sec_alarm = r_q.alarm_seen;
  // product form avoids a divider in the per-second path
  assign sec_ses = sec_alarm || ((64'(r_q.err_cnt) * SES_RATIO_DEN) >= 64'(LINE_RATE_BPS));
  // a second closes on the tick only while measuring with power present
  assign sec_end = r_q.tick && r_q.measuring && r_q.pwr_s2;

  always_comb begin
    r_d = r_q;
    // run and power are pins: two flops before any logic reads them
    r_d.run_s1 = MEAS_RUN_I;
    r_d.run_s2 = r_q.run_s1;
    r_d.run_d = r_q.run_s2;
    r_d.pwr_s1 = POWER_OK_I;
    r_d.pwr_s2 = r_q.pwr_s1;
    r_d.measuring = r_q.run_s2;

    // one-second tick from the instrument clock
    if (r_q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      r_d.tick_cnt = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.tick_cnt = r_q.tick_cnt + 32'h0000_0001;
      r_d.tick = 1'b0;
    end

    // per-second gathering; an event in the closing cycle opens the next second
    if (r_q.tick) begin
      r_d.err_cnt = {{(CW-1){1'b0}}, ERR_I};
      r_d.alarm_seen = alarm_now;
    end else begin
      // saturate so a long burst can never wrap to an error-free count
      if (ERR_I && (r_q.err_cnt != '1)) begin
        r_d.err_cnt = r_q.err_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      r_d.alarm_seen = r_q.alarm_seen || alarm_now;
    end

    if (sec_end) begin
      r_d.total = r_q.total + ext4(4'h1);
      case (r_q.state)
        ST_AVAIL: begin
          if (sec_ses) begin
            // provisionally available until the run is decided
            r_d.severe_second_count = r_q.severe_second_count + ext4(4'h1);
            r_d.p_ses = r_q.p_ses + 4'h1;
            if (sec_err) begin
              r_d.es = r_q.es + ext4(4'h1);
              r_d.p_es = r_q.p_es + 4'h1;
            end else begin
              r_d.p_es = r_q.p_es;
            end
            if (sec_alarm) begin
              r_d.alarm_second_count = r_q.alarm_second_count + ext4(4'h1);
              r_d.p_als = r_q.p_als + 4'h1;
            end
            r_d.run_len = r_q.run_len + 4'h1;
            if (r_q.run_len + 4'h1 == UNAV_RUN) begin
              // confirmed: take the whole run back out of the available counts
              r_d.es = r_q.es + ext4(one_if(sec_err)) - ext4(r_d.p_es);
              r_d.severe_second_count = r_q.severe_second_count + ext4(4'h1) - ext4(r_d.p_ses);
              r_d.alarm_second_count = r_q.alarm_second_count + ext4(one_if(sec_alarm)) - ext4(r_d.p_als);
              r_d.unav = r_q.unav + ext4(UNAV_RUN);
              r_d.state = ST_UNAVAIL;
              r_d.run_len = '0;
              r_d.p_es = '0;
              r_d.p_ses = '0;
              r_d.p_als = '0;
              r_d.p_efs = '0;
              r_d.p_bbe = '0;
            end
          end else begin
            // a non-severe second breaks the candidate run
            r_d.run_len = '0;
            r_d.p_es = '0;
            r_d.p_ses = '0;
            r_d.p_als = '0;
            if (sec_err) begin
              r_d.es = r_q.es + ext4(4'h1);
            end else begin
              r_d.error_free_second_count = r_q.error_free_second_count + ext4(4'h1);
            end
            r_d.bbe = r_q.bbe + r_q.err_cnt;
          end
        end
        ST_UNAVAIL: begin
          // every second counts unavailable until an end is confirmed
          r_d.unav = r_q.unav + ext4(4'h1);
          if (sec_ses) begin
            // a severe second breaks the exit run
            r_d.run_len = '0;
            r_d.p_es = '0;
            r_d.p_efs = '0;
            r_d.p_bbe = '0;
          end else begin
            r_d.run_len = r_q.run_len + 4'h1;
            r_d.p_es = r_q.p_es + one_if(sec_err);
            r_d.p_efs = r_q.p_efs + one_if(!sec_err);
            r_d.p_bbe = r_q.p_bbe + r_q.err_cnt;
            if (r_q.run_len + 4'h1 == UNAV_RUN) begin
              // confirmed: the run becomes available time, unavailable total drops
              r_d.unav = r_q.unav + ext4(4'h1) - ext4(UNAV_RUN);
              r_d.es = r_q.es + ext4(r_d.p_es);
              r_d.error_free_second_count = r_q.error_free_second_count + ext4(r_d.p_efs);
              r_d.bbe = r_q.bbe + r_d.p_bbe;
              r_d.state = ST_AVAIL;
              r_d.run_len = '0;
              r_d.p_es = '0;
              r_d.p_efs = '0;
              r_d.p_bbe = '0;
            end
          end
        end
        default: begin
          // an illegal state code falls back to available
          r_d.state = ST_AVAIL;
          r_d.run_len = '0;
        end
      endcase
    end

    // rising edge of the run request restarts the whole measurement
    // a pending run is dropped too: the new measurement has no history
    if (r_q.run_s2 && !r_q.run_d) begin
      r_d.tick_cnt = '0;
      r_d.tick = 1'b0;
      r_d.err_cnt = '0;
      r_d.alarm_seen = 1'b0;
      r_d.state = ST_AVAIL;
      r_d.run_len = '0;
      r_d.p_es = '0;
      r_d.p_ses = '0;
      r_d.p_als = '0;
      r_d.p_efs = '0;
      r_d.p_bbe = '0;
      r_d.total = '0;
      r_d.unav = '0;
      r_d.es = '0;
      r_d.severe_second_count = '0;
      r_d.alarm_second_count = '0;
      r_d.error_free_second_count = '0;
      r_d.bbe = '0;
    end

    // results lag the counters by one cycle; the pass flags lag total and unavailable time by two
    r_d.avail = r_q.total - r_q.unav;
    r_d.bbe_valid = (STD_SEL_I == STD_SECOND);
    r_d.es_pass = ratio_ok(r_q.es, r_q.avail, es_obj);
    r_d.ses_pass = ratio_ok(r_q.severe_second_count, r_q.avail, ses_obj);
    // registered copy so the status pin comes straight from a flop
    r_d.unav_flag = (r_d.state == ST_UNAVAIL);
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r_q <= '{state: ST_AVAIL, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign SECOND_TICK_O = r_q.tick;
  assign UNAVAIL_O = r_q.unav_flag;
  assign TOTAL_TIME_O = r_q.total;
  assign UNAVAILABLE_TIME_O = r_q.unav;
  assign AVAILABLE_TIME_O = r_q.avail;
  assign ERRORED_SECOND_COUNT_O = r_q.es;
  assign SEVERE_SECOND_COUNT_O = r_q.severe_second_count;
  assign ALARM_SECOND_COUNT_O = r_q.alarm_second_count;
  assign ERROR_FREE_SECOND_COUNT_O = r_q.error_free_second_count;
  assign BACKGROUND_ERROR_COUNT_O = r_q.bbe;
  assign BACKGROUND_VALID_O = r_q.bbe_valid;
  assign ES_PASS_O = r_q.es_pass;
  assign SES_PASS_O = r_q.ses_pass;

endmodule // pdhm_monitor

// ===== tb/pdhm_framer_model.sv
`timescale 1ns/100ps
module pdhm_framer_model (
  input wire logic clk_i,
  input wire logic tick_i,
  input wire logic [4:0] n_err_i,
  input wire logic alarm_i,
  input wire logic los_i,
  output logic err_o,
  output logic alarm_o,
  output logic los_o
);
  logic [4:0] cnt_q = 5'h1f;
  // burst restarts at each tick so every second gets exactly n errors
  always @(posedge clk_i) begin
    cnt_q <= tick_i ? 5'h00 : (cnt_q == 5'h1f ? cnt_q : cnt_q + 5'h01);
  end
  // nothing shows in the tick cycle: it already belongs to the next second
  assign err_o = !tick_i && (cnt_q < n_err_i);
  assign alarm_o = alarm_i && !tick_i;
  assign los_o = los_i && !tick_i;
endmodule // pdhm_framer_model

// ===== tb/pdhm_monitor_props.sv
`timescale 1ns/100ps
module pdhm_props #(
  parameter int CW = 32
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [1:0] STD_SEL_I,
  input wire logic SECOND_TICK_O,
  input wire logic UNAVAIL_O,
  input wire logic [CW-1:0] TOTAL_TIME_O,
  input wire logic [CW-1:0] UNAVAILABLE_TIME_O,
  input wire logic [CW-1:0] AVAILABLE_TIME_O,
  input wire logic [CW-1:0] SEVERE_SECOND_COUNT_O,
  input wire logic BACKGROUND_VALID_O,
  input wire logic SES_PASS_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_enter_unav;
    $rose(UNAVAIL_O);
  endsequence
  sequence s_ses_quiet;
    (SEVERE_SECOND_COUNT_O == '0) [*4];
  endsequence
  a_tick_single: assert property (SECOND_TICK_O |=> !SECOND_TICK_O [*8])
    else $error("tick not a single pulse");
  a_total_step: assert property ($changed(TOTAL_TIME_O) && TOTAL_TIME_O != '0 |->
    $past(SECOND_TICK_O) && TOTAL_TIME_O == $past(TOTAL_TIME_O) + 1)
    else $error("total time stepped wrongly");
  // a restart clears the total one cycle before it clears available time
  a_avail_calc: assert property (1'b1 |=> TOTAL_TIME_O == '0 ||
    AVAILABLE_TIME_O == $past(TOTAL_TIME_O) - $past(UNAVAILABLE_TIME_O))
    else $error("available time not total minus unavailable");
  a_unav_entry: assert property (s_enter_unav |->
    UNAVAILABLE_TIME_O == $past(UNAVAILABLE_TIME_O) + 10)
    else $error("entry did not add ten seconds");
  a_ses_rollback: assert property (s_enter_unav |->
    SEVERE_SECOND_COUNT_O == $past(SEVERE_SECOND_COUNT_O) - 9)
    else $error("severe count not corrected on entry");
  a_unav_exit: assert property (UNAVAILABLE_TIME_O < $past(UNAVAILABLE_TIME_O) &&
    UNAVAILABLE_TIME_O != '0 |-> $fell(UNAVAIL_O) && $past(UNAVAILABLE_TIME_O) - UNAVAILABLE_TIME_O == 9)
    else $error("exit correction wrong");
  a_unav_growth: assert property ($changed(UNAVAILABLE_TIME_O) && UNAVAILABLE_TIME_O != '0 &&
    !$rose(UNAVAIL_O) && !$fell(UNAVAIL_O) |-> UNAVAIL_O && UNAVAILABLE_TIME_O == $past(UNAVAILABLE_TIME_O) + 1)
    else $error("unavailable time grew while available");
  a_bg_valid: assert property (1'b1 |=> BACKGROUND_VALID_O == ($past(STD_SEL_I) == 2'h1))
    else $error("background valid wrong");
  a_ses_pass_zero: assert property (s_ses_quiet |-> SES_PASS_O)
    else $error("zero severe count not passing");
endmodule // pdhm_props
bind pdhm_monitor pdhm_props #(.CW(CW)) u_props (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .STD_SEL_I(STD_SEL_I),
  .SECOND_TICK_O(SECOND_TICK_O), .UNAVAIL_O(UNAVAIL_O), .TOTAL_TIME_O(TOTAL_TIME_O),
  .UNAVAILABLE_TIME_O(UNAVAILABLE_TIME_O), .AVAILABLE_TIME_O(AVAILABLE_TIME_O),
  .SEVERE_SECOND_COUNT_O(SEVERE_SECOND_COUNT_O), .BACKGROUND_VALID_O(BACKGROUND_VALID_O), .SES_PASS_O(SES_PASS_O));

// ===== tb/test_pdhm_error_performance_monitor.sv
`timescale 1ns/100ps
module test_pdhm_error_performance_monitor;
  localparam int CW = 32;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, pwr = 1'b1, a_en = 1'b0, l_en = 1'b0;
  logic err, alm, loss_of_signal, tick, unav, bgv, esp, sesp;
  logic [4:0] n_err = 5'h00;
  logic [1:0] std = 2'h0;
  logic [CW-1:0] tt, ut, available_time, esc, sesc, alsc, efsc, bbe;
  int n_mismatch = 0, tests_run = 0;
  always #10 clk = ~clk;
  pdhm_framer_model fr (.clk_i(clk), .tick_i(tick), .n_err_i(n_err), .alarm_i(a_en), .los_i(l_en),
    .err_o(err), .alarm_o(alm), .los_o(loss_of_signal));
  // 4000 bit/s line: four errors in a second make it severe
  pdhm_monitor #(.CW(CW), .TICK_CYCLES(20), .LINE_RATE_BPS(4000)) dut (.REF_CLK_I(clk), .NRST_I(rst_n),
    .MEAS_RUN_I(run), .POWER_OK_I(pwr), .ERR_I(err), .ALARM_IND_I(alm), .LOSS_OF_SIGNAL_I(loss_of_signal),
    .STD_SEL_I(std), .SECOND_TICK_O(tick), .UNAVAIL_O(unav), .TOTAL_TIME_O(tt), .UNAVAILABLE_TIME_O(ut),
    .AVAILABLE_TIME_O(available_time), .ERRORED_SECOND_COUNT_O(esc), .SEVERE_SECOND_COUNT_O(sesc),
    .ALARM_SECOND_COUNT_O(alsc), .ERROR_FREE_SECOND_COUNT_O(efsc), .BACKGROUND_ERROR_COUNT_O(bbe),
    .BACKGROUND_VALID_O(bgv), .ES_PASS_O(esp), .SES_PASS_O(sesp));
  task automatic chk_cnt(input string nm, input logic [CW-1:0] exp, input logic [CW-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic counts(input int t, u, e, s, a, f, b);
    chk_cnt("total", t, tt);
    chk_cnt("unavail", u, ut);
    chk_cnt("errored", e, esc);
    chk_cnt("severe", s, sesc);
    chk_cnt("alarm", a, alsc);
    chk_cnt("errfree", f, efsc);
    chk_cnt("backgr", b, bbe);
  endtask
  // sets the next second's stimulus as the previous one closes
  task automatic sec(input logic [4:0] n, input logic a, input logic l);
    @(posedge clk iff tick);
    n_err <= n;
    a_en <= a;
    l_en <= l;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic restart;
    @(posedge clk);
    run <= 1'b0;
    n_err <= 5'h00;
    a_en <= 1'b0;
    l_en <= 1'b0;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_classify;
    restart();
    sec(5'h02, 1'b0, 1'b0);
    sec(5'h04, 1'b0, 1'b0);
    counts(2, 0, 1, 0, 0, 1, 2);
    sec(5'h00, 1'b1, 1'b0);
    sec(5'h03, 1'b0, 1'b0);
    sec(5'h00, 1'b0, 1'b0);
    counts(5, 0, 3, 2, 1, 1, 5);
    $display("t_classify done");
  endtask
  task automatic t_power;
    @(posedge clk);
    pwr <= 1'b0;
    sec(5'h00, 1'b0, 1'b0);
    sec(5'h00, 1'b0, 1'b0);
    @(posedge clk);
    pwr <= 1'b1;
    counts(5, 0, 3, 2, 1, 1, 5);
    $display("t_power done");
  endtask
  task automatic t_unavail;
    for (int i = 0; i < 10; i++) sec(5'h00, 1'b0, 1'b1);
    chk_flag("unav", 1'b0, unav);
    counts(15, 0, 3, 11, 10, 2, 5);
    // one error in the first exit second exercises the pending counts
    sec(5'h01, 1'b0, 1'b0);
    chk_flag("unav", 1'b1, unav);
    counts(16, 10, 3, 2, 1, 2, 5);
    chk_cnt("avail", 6, available_time);
    for (int i = 0; i < 9; i++) sec(5'h00, 1'b0, 1'b0);
    counts(25, 19, 3, 2, 1, 2, 5);
    sec(5'h00, 1'b0, 1'b0);
    chk_flag("unav", 1'b0, unav);
    counts(26, 10, 4, 2, 1, 11, 6);
    chk_cnt("avail", 16, available_time);
    $display("t_unavail done");
  endtask
  task automatic t_ratio;
    logic [3:0] es_exp;
    es_exp = 4'h1;
    restart();
    sec(5'h01, 1'b0, 1'b0);
    repeat (12) sec(5'h00, 1'b0, 1'b0);
    chk_cnt("avail", 13, available_time);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      std <= s[1:0];
      repeat (3) @(posedge clk);
      #1;
      chk_flag("es_pass", es_exp[s], esp);
      chk_flag("ses_pass", 1'b1, sesp);
      chk_flag("bg_valid", s == 1, bgv);
    end
    sec(5'h00, 1'b1, 1'b0);
    sec(5'h00, 1'b0, 1'b0);
    chk_cnt("severe", 1, sesc);
    chk_flag("ses_pass", 1'b0, sesp);
    $display("t_ratio done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_classify();
    t_power();
    t_unavail();
    t_ratio();
    report_and_stop();
  end
  // about 46 seconds of 20 cycles are expected
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // test_pdhm_error_performance_monitor
